// file: pkg/sbc_mode_pkg.sv
package sbc_mode_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int unsigned CLK_PERIOD_NS  = 50;
    localparam int unsigned RESET_DELAY_US = 10000;
    localparam int unsigned LONG_WINDOW_US = 200000;
    localparam int unsigned CFG_FILTER_US  = 10;

    // least times: round up to whole cycles
    function automatic int unsigned us_to_cycles(input int unsigned t_us);
        return (t_us * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction : us_to_cycles

    localparam int unsigned RESET_DELAY_CYCLES = us_to_cycles(RESET_DELAY_US);
    localparam int unsigned LONG_WINDOW_CYCLES = us_to_cycles(LONG_WINDOW_US);
    localparam int unsigned CFG_FILTER_CYCLES  = us_to_cycles(CFG_FILTER_US);
    localparam int unsigned COUNT_W            = 22;
    localparam int unsigned FILTER_W           = 8;

    ////////////////////////////////////////////////////////////////////////////
    // serial frame layout
    localparam int unsigned FRAME_BITS = 16;
    localparam int unsigned WRITE_BIT  = 15;
    localparam int unsigned ADDR_MSB   = 14;
    localparam int unsigned ADDR_LSB   = 8;
    localparam logic [6:0] ADDR_MODE_SUPPLY = 7'h01;
    localparam logic [6:0] ADDR_HARDWARE_CONTROL_REG     = 7'h02;
    localparam logic [6:0] ADDR_WD_CTRL     = 7'h03;
    localparam logic [6:0] ADDR_FLAG_CLEAR  = 7'h04;

    // field positions
    localparam int unsigned CFG_BIT     = 0;
    localparam int unsigned OV_RST_BIT  = 1;
    localparam int unsigned CLR_POR_BIT = 0;
    localparam int unsigned CLR_OV_BIT  = 1;
    localparam int unsigned CLR_UV_BIT  = 2;

    // mode field encodings
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_SLEEP  = 2'h1;
    localparam logic [1:0] MODE_STOP   = 2'h2;

    // reset values
    localparam logic [2:0] WD_PERIOD_RESET = 3'h4;
    localparam logic       CFG_SW_RESET    = 1'h0;
    localparam logic       OV_RST_RESET    = 1'h0;

    typedef enum logic [5:0] {
        ST_INIT     = 6'h01,
        ST_NORMAL   = 6'h02,
        ST_STOP     = 6'h04,
        ST_SLEEP    = 6'h08,
        ST_RESTART  = 6'h10,
        ST_FAILSAFE = 6'h20
    } sbc_state_t;

endpackage : sbc_mode_pkg

// file: design/cfg_pin_filter.sv
`timescale 1ns/10ps
module cfg_pin_filter (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic resetn,
    // synchronised sample
    input  wire logic sample_in,
    // filtered level and stability
    output logic      level,
    output logic      stable
);

    logic [sbc_mode_pkg::FILTER_W-1:0] count;
    logic                              last;

    localparam logic [sbc_mode_pkg::FILTER_W-1:0] LIMIT =
        sbc_mode_pkg::FILTER_W'(sbc_mode_pkg::CFG_FILTER_CYCLES - 1);

    wire same = (sample_in == last);
    wire full = (count == LIMIT);

    // continuous filter: level follows input only after a quiet interval
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            count  <= '0;
            last   <= 1'b0;
            level  <= 1'b0;
            stable <= 1'b0;
        end else begin
            last   <= sample_in;
            count  <= !same ? '0 : (full ? count : count + 1'b1);
            stable <= same && full;
            if (same && full) begin
                level <= last;
            end
        end
    end

endmodule : cfg_pin_filter

// file: design/spi_frame_rx.sv
`timescale 1ns/10ps
module spi_frame_rx (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // serial pins
    input  wire logic        spi_sclk,
    input  wire logic        spi_cs_n,
    input  wire logic        spi_mosi,
    // received frame
    output logic             frame_done,
    output logic             frame_full,
    output logic [15:0]      frame_data
);

    logic [2:0] sync1;
    logic [2:0] sync2;
    logic       sclk_q;
    logic       cs_q;
    logic [4:0] bit_count;
    logic [15:0] shift;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sync1 <= 3'h3;
            sync2 <= 3'h3;
        end else begin
            sync1 <= {spi_sclk, spi_cs_n, spi_mosi};
            sync2 <= sync1;
        end
    end

    wire sclk_rise = sync2[2] && !sclk_q;
    wire cs_rise   = sync2[1] && !cs_q;
    wire selected  = !sync2[1];

    // mode 0 sampling, msb first; frame ends on deselect
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sclk_q     <= 1'b0;
            cs_q       <= 1'b1;
            bit_count  <= '0;
            shift      <= '0;
            frame_done <= 1'b0;
            frame_full <= 1'b0;
            frame_data <= '0;
        end else begin
            sclk_q     <= sync2[2];
            cs_q       <= sync2[1];
            frame_done <= cs_rise;
            if (cs_rise) begin
                frame_full <= (bit_count == 5'(sbc_mode_pkg::FRAME_BITS));
                frame_data <= shift;
                bit_count  <= '0;
            end else if (selected && sclk_rise) begin
                shift     <= {shift[14:0], sync2[0]};
                bit_count <= (bit_count == 5'h1f) ? bit_count : bit_count + 1'b1;
            end
        end
    end

endmodule : spi_frame_rx

// file: design/sbc_mode_state_machine.sv
`timescale 1ns/10ps
// Overview of operation
// - six modes; main regulator on except in sleep and fail-safe
// - wake from sleep/fail-safe or failure with pin value one enters restart, then normal after delay
// - fail-safe keeps regulator off until wake or over-temperature clears
// - development mode reaches all modes with the watchdog halted
// - strap pin low during init selects development mode
// - configuration and diagnosis exchanged over 16-bit serial frames
// - mode field written by controller, cleared while passing restart
// - power-up starts in init with a long open watchdog window
// - pull interrupt pin low in reset delay, filter it, latch on reset rise
// - while power-on flag set, every reset re-latches the configuration
// - unstable interrupt pin latches zero, selecting fail-safe behaviour
// - pin value one: watchdog failure restarts; fail outputs per config bit, or on any repeat failure
// - pin value zero: failure to fail-safe; config bit zero first restarts
// - over-voltage with reset enable sets flag, fail outputs, restart/fail-safe
// - over-voltage without reset enable only sets the flag
// - software config bit and latched pin value are readable
// - latched configuration changes only at reset release while power-on flag set
// - any frame in init after reset release moves to normal, valid or illegal
// - missing service in long window records a watchdog failure, restart or fail-safe as above
// - wake events in init are discarded
// - reset held low below threshold; no undervolt flag or fail at power-up
// - restart drives reset low; release starts long window, period default
module sbc_mode_state_machine #(
    parameter int unsigned RESET_DELAY_CYCLES = sbc_mode_pkg::RESET_DELAY_CYCLES,
    parameter int unsigned LONG_WINDOW_CYCLES = sbc_mode_pkg::LONG_WINDOW_CYCLES
) (
    // clock and power-on reset
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    // supply monitors (asynchronous levels)
    input  wire logic       main_reg_ok_pin,
    input  wire logic       supply_ok_pin,
    input  wire logic       main_reg_undervolt_pin,
    input  wire logic       main_reg_overvolt_pin,
    input  wire logic       overtemp_pin,
    // wake sources (asynchronous levels)
    input  wire logic       bus_wake_pin,
    input  wire logic [2:0] wake_inputs,
    // configuration pins
    input  wire logic       int_pin_in,
    input  wire logic       fail3_test_strap_pin,
    output logic            int_pulldown_en,
    // serial port
    input  wire logic       spi_sclk,
    input  wire logic       spi_cs_n,
    input  wire logic       spi_mosi,
    // watchdog block, same clock
    input  wire logic       watchdog_fail,
    // mode and supply outputs
    output sbc_mode_pkg::sbc_state_t mode_state,
    output logic            reset_output,
    output logic            main_reg_enable,
    output logic [2:0]      fail_outputs,
    output logic            watchdog_halted,
    output logic            long_window_active,
    // readable state
    output logic [1:0]      mode_field,
    output logic [2:0]      wd_period,
    output logic            hardware_control_reg,
    output logic            main_reg_overvolt_reset_enable,
    output logic            wake_level_status_reg,
    output logic            latched_pin_config,
    output logic            dev_mode,
    output logic            power_on_flag,
    output logic            main_reg_overvolt_flag,
    output logic            main_reg_undervolt_flag,
    output logic [1:0]      wd_fail_count
);

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic [9:0] sync1;
    logic [9:0] sync2;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {main_reg_ok_pin, supply_ok_pin, main_reg_undervolt_pin,
                      main_reg_overvolt_pin, overtemp_pin, bus_wake_pin,
                      wake_inputs, fail3_test_strap_pin};
            sync2 <= sync1;
        end
    end

    wire main_ok_s = sync2[9];
    wire supply_s  = sync2[8];
    wire uv_s      = sync2[7];
    wire ov_s      = sync2[6];
    wire ot_s      = sync2[5];
    wire wake_s    = |sync2[4:1];
    wire strap_s   = sync2[0];

    logic int_s1;
    logic int_s2;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            int_s1 <= 1'b0;
            int_s2 <= 1'b0;
        end else begin
            int_s1 <= int_pin_in;
            int_s2 <= int_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // submodules
    logic        cfg_level;
    logic        cfg_stable;
    logic        frame_done;
    logic        frame_full;
    logic [15:0] frame_data;

    cfg_pin_filter u_filter (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .sample_in (int_s2),
        .level     (cfg_level),
        .stable    (cfg_stable)
    );

    spi_frame_rx u_spi (
        .clk_sys    (clk_sys),
        .resetn     (resetn),
        .spi_sclk   (spi_sclk),
        .spi_cs_n   (spi_cs_n),
        .spi_mosi   (spi_mosi),
        .frame_done (frame_done),
        .frame_full (frame_full),
        .frame_data (frame_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // frame decode
    sbc_mode_pkg::sbc_state_t state;
    sbc_mode_pkg::sbc_state_t next_state;

    logic ov_q;
    logic uv_q;
    logic ot_q;
    logic [sbc_mode_pkg::COUNT_W-1:0] rd_count;
    logic [sbc_mode_pkg::COUNT_W-1:0] lw_count;

    // frames are not interpreted while reset is held
    wire frame_seen = frame_done && reset_output;
    wire [6:0] addr = frame_data[sbc_mode_pkg::ADDR_MSB:sbc_mode_pkg::ADDR_LSB];
    wire wr_cmd     = frame_seen && frame_full && frame_data[sbc_mode_pkg::WRITE_BIT];
    wire wr_mode    = wr_cmd && (addr == sbc_mode_pkg::ADDR_MODE_SUPPLY);
    wire wr_hw      = wr_cmd && (addr == sbc_mode_pkg::ADDR_HARDWARE_CONTROL_REG);
    wire wr_wd      = wr_cmd && (addr == sbc_mode_pkg::ADDR_WD_CTRL);
    wire wr_clr     = wr_cmd && (addr == sbc_mode_pkg::ADDR_FLAG_CLEAR);
    wire [1:0] req_mode = frame_data[1:0];

    ////////////////////////////////////////////////////////////////////////////
    // failure events
    wire st_active = (state == sbc_mode_pkg::ST_INIT) ||
                     (state == sbc_mode_pkg::ST_NORMAL) ||
                     (state == sbc_mode_pkg::ST_STOP);
    wire powered   = supply_s && main_ok_s;
    wire ov_rise   = ov_s && !ov_q;
    wire uv_rise   = uv_s && !uv_q;
    wire ot_fall   = !ot_s && ot_q;
    wire lw_timeout = long_window_active &&
        (lw_count == sbc_mode_pkg::COUNT_W'(LONG_WINDOW_CYCLES - 1));
    wire wd_evt    = st_active && !dev_mode &&
                     (watchdog_fail || lw_timeout);
    wire wd_to_fo  = hardware_control_reg || (wd_fail_count != 2'h0);
    wire ov_trip   = st_active && ov_rise &&
                     main_reg_overvolt_reset_enable;
    wire uv_trip   = (state != sbc_mode_pkg::ST_INIT) && st_active &&
                     reset_output && uv_s && powered;

    wire sbc_mode_pkg::sbc_state_t fault_target =
        latched_pin_config ? sbc_mode_pkg::ST_RESTART
                           : sbc_mode_pkg::ST_FAILSAFE;
    wire sbc_mode_pkg::sbc_state_t wd_target =
        wd_to_fo ? fault_target : sbc_mode_pkg::ST_RESTART;

    ////////////////////////////////////////////////////////////////////////////
    // reset delay
    wire fault_gone = main_ok_s && !uv_s;
    wire rd_run     = !reset_output && fault_gone &&
                      ((state == sbc_mode_pkg::ST_INIT) ||
                       (state == sbc_mode_pkg::ST_RESTART));
    wire rd_done    = rd_run &&
        (rd_count == sbc_mode_pkg::COUNT_W'(RESET_DELAY_CYCLES - 1));

    ////////////////////////////////////////////////////////////////////////////
    // next mode
    always_comb begin
        next_state = state;
        unique case (state)
            sbc_mode_pkg::ST_INIT: begin
                if (frame_seen) begin
                    next_state = sbc_mode_pkg::ST_NORMAL;
                end
            end
            sbc_mode_pkg::ST_NORMAL: begin
                if (wr_mode && (req_mode == sbc_mode_pkg::MODE_SLEEP)) begin
                    next_state = sbc_mode_pkg::ST_SLEEP;
                end else if (wr_mode && (req_mode == sbc_mode_pkg::MODE_STOP)) begin
                    next_state = sbc_mode_pkg::ST_STOP;
                end
            end
            sbc_mode_pkg::ST_STOP: begin
                if (wr_mode && (req_mode == sbc_mode_pkg::MODE_NORMAL)) begin
                    next_state = sbc_mode_pkg::ST_NORMAL;
                end
            end
            sbc_mode_pkg::ST_SLEEP: begin
                if (wake_s) begin
                    next_state = sbc_mode_pkg::ST_RESTART;
                end
            end
            sbc_mode_pkg::ST_RESTART: begin
                if (rd_done) begin
                    next_state = sbc_mode_pkg::ST_NORMAL;
                end
            end
            sbc_mode_pkg::ST_FAILSAFE: begin
                if (wake_s || ot_fall) begin
                    next_state = sbc_mode_pkg::ST_RESTART;
                end
            end
            default: begin
                next_state = sbc_mode_pkg::ST_INIT;
            end
        endcase
        // failures override any requested mode; wakes in init never act
        if (ov_trip) begin
            next_state = fault_target;
        end else if (wd_evt) begin
            next_state = wd_target;
        end else if (uv_trip) begin
            next_state = sbc_mode_pkg::ST_RESTART;
        end
    end

    wire next_ro = ((next_state == sbc_mode_pkg::ST_INIT) ||
                    (next_state == sbc_mode_pkg::ST_NORMAL) ||
                    (next_state == sbc_mode_pkg::ST_STOP)) &&
                   (reset_output || rd_done);
    wire ro_rise = next_ro && !reset_output;

    ////////////////////////////////////////////////////////////////////////////
    // mode register and counters
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state        <= sbc_mode_pkg::ST_INIT;
            reset_output <= 1'b0;
            ov_q         <= 1'b0;
            uv_q         <= 1'b0;
            ot_q         <= 1'b0;
            rd_count     <= '0;
        end else begin
            state        <= next_state;
            reset_output <= next_ro;
            ov_q         <= ov_s;
            uv_q         <= uv_s;
            ot_q         <= ot_s;
            rd_count     <= rd_run ? rd_count + 1'b1 : '0;
        end
    end

    // long open window begins at reset release
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            long_window_active <= 1'b0;
            lw_count           <= '0;
        end else if (ro_rise) begin
            long_window_active <= !dev_mode;
            lw_count           <= '0;
        end else if (wr_wd || lw_timeout || dev_mode || !reset_output) begin
            long_window_active <= 1'b0;
            lw_count           <= '0;
        end else if (long_window_active) begin
            lw_count <= lw_count + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration latch
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            latched_pin_config <= 1'b0;
            dev_mode           <= 1'b0;
        end else begin
            if (ro_rise && power_on_flag) begin
                latched_pin_config <= cfg_stable && cfg_level;
            end
            if (ro_rise && (state == sbc_mode_pkg::ST_INIT) && power_on_flag) begin
                dev_mode <= !strap_s;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // software registers and flags
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mode_field                     <= sbc_mode_pkg::MODE_NORMAL;
            wd_period                      <= sbc_mode_pkg::WD_PERIOD_RESET;
            hardware_control_reg           <= sbc_mode_pkg::CFG_SW_RESET;
            main_reg_overvolt_reset_enable <= sbc_mode_pkg::OV_RST_RESET;
        end else begin
            if (state == sbc_mode_pkg::ST_RESTART) begin
                mode_field <= sbc_mode_pkg::MODE_NORMAL;
                wd_period  <= sbc_mode_pkg::WD_PERIOD_RESET;
            end else begin
                if (wr_mode && (state != sbc_mode_pkg::ST_INIT)) begin
                    mode_field <= req_mode;
                end
                if (wr_wd) begin
                    wd_period <= frame_data[2:0];
                end
            end
            if (wr_hw) begin
                hardware_control_reg           <= frame_data[sbc_mode_pkg::CFG_BIT];
                main_reg_overvolt_reset_enable <= frame_data[sbc_mode_pkg::OV_RST_BIT];
            end
        end
    end

    // hardware sets win over a clear in the same cycle
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            power_on_flag           <= 1'b1;
            main_reg_overvolt_flag  <= 1'b0;
            main_reg_undervolt_flag <= 1'b0;
        end else begin
            if (wr_clr && frame_data[sbc_mode_pkg::CLR_POR_BIT]) begin
                power_on_flag <= 1'b0;
            end
            if (ov_rise && powered) begin
                main_reg_overvolt_flag <= 1'b1;
            end else if (wr_clr && frame_data[sbc_mode_pkg::CLR_OV_BIT]) begin
                main_reg_overvolt_flag <= 1'b0;
            end
            if (uv_rise && powered && reset_output) begin
                main_reg_undervolt_flag <= 1'b1;
            end else if (wr_clr && frame_data[sbc_mode_pkg::CLR_UV_BIT]) begin
                main_reg_undervolt_flag <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // failure count and fail outputs; leaving restart keeps them on
    logic fail_on;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wd_fail_count <= 2'h0;
            fail_on       <= 1'b0;
        end else begin
            if (wd_evt && (wd_fail_count != 2'h3)) begin
                wd_fail_count <= wd_fail_count + 2'h1;
            end
            if ((wd_evt && wd_to_fo) || ov_trip) begin
                fail_on <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign mode_state      = state;
    assign fail_outputs    = {3{fail_on}};
    assign main_reg_enable = (state != sbc_mode_pkg::ST_SLEEP) &&
                             (state != sbc_mode_pkg::ST_FAILSAFE);
    assign watchdog_halted = dev_mode;
    assign int_pulldown_en = !reset_output && power_on_flag && main_ok_s;
    assign wake_level_status_reg = latched_pin_config;

endmodule : sbc_mode_state_machine

// file: tb/sbc_mode_asserts.sv
`timescale 1ns/10ps
module sbc_mode_asserts (
    // clock and reset
    input wire logic                     clk_sys, resetn,
    // watched outputs
    input wire sbc_mode_pkg::sbc_state_t mode_state,
    input wire logic                     reset_output, main_reg_enable, watchdog_halted,
    input wire logic                     dev_mode, int_pulldown_en, latched_pin_config,
    input wire logic                     wake_level_status_reg, main_reg_overvolt_flag,
    input wire logic                     main_reg_overvolt_reset_enable,
    input wire logic [1:0]               mode_field,
    input wire logic [2:0]               wd_period, fail_outputs
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////////
    reg_power_a: assert property (main_reg_enable == !(mode_state[3] || mode_state[5]))
        else $error("main regulator enable wrong for mode");
    restart_field_a: assert property (mode_state[4] |=>
        !mode_state[4] || (mode_field == 2'h0 && wd_period == 3'h4))
        else $error("mode field or period not cleared in restart");
    restart_reset_a: assert property (mode_state[4] |-> !reset_output)
        else $error("reset output high in restart");
    dev_halt_a: assert property (watchdog_halted == dev_mode)
        else $error("watchdog halt differs from development mode");
    cfg_mirror_a: assert property (wake_level_status_reg == latched_pin_config)
        else $error("readable pin config differs");
    cfg_latch_a: assert property ($changed(latched_pin_config) |-> $rose(reset_output))
        else $error("pin config changed away from reset release");
    pulldown_window_a: assert property (int_pulldown_en |-> !reset_output)
        else $error("pulldown on after reset release");
    fail_sticky_a: assert property (fail_outputs == 3'h7 |=> fail_outputs == 3'h7)
        else $error("fail outputs released");
    ov_quiet_a: assert property ($rose(main_reg_overvolt_flag) &&
        !main_reg_overvolt_reset_enable |-> $stable(fail_outputs) && $stable(mode_state))
        else $error("overvoltage without enable acted");
    cover property ($rose(mode_state[4]));
    cover property ($rose(mode_state[5]));
    cover property ($rose(fail_outputs[0]));
endmodule : sbc_mode_asserts
bind sbc_mode_state_machine sbc_mode_asserts i_asserts (.*);

// file: tb/sbc_host_model.sv
`timescale 1ns/10ps
module sbc_host_model (
    // clock
    input  wire logic clk_sys,
    // serial pins
    output logic      spi_sclk = 1'b0,
    output logic      spi_cs_n = 1'b1,
    output logic      spi_mosi = 1'b0
);
    // mode 0, msb first; clock stands low between frames
    task automatic send(input logic [15:0] f, input int n);
        spi_cs_n <= 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            spi_mosi <= f[i];
            repeat (4) @(posedge clk_sys);
            spi_sclk <= 1'b1;
            repeat (4) @(posedge clk_sys);
            spi_sclk <= 1'b0;
        end
        repeat (4) @(posedge clk_sys);
        spi_cs_n <= 1'b1;
        spi_mosi <= ~spi_mosi;
        repeat (8) @(posedge clk_sys);
    endtask : send
endmodule : sbc_host_model

// file: tb/tb_sbc_mode_state_machine.sv
`timescale 1ns/10ps
module tb_sbc_mode_state_machine;
    localparam int RD = 400;
    logic clk_sys = 1'b0, resetn = 1'b0, main_reg_ok_pin = 1'b0, supply_ok_pin = 1'b1;
    logic main_reg_undervolt_pin = 1'b0, main_reg_overvolt_pin = 1'b0, overtemp_pin = 1'b0;
    logic bus_wake_pin = 1'b0, int_pin_in = 1'b1, fail3_test_strap_pin = 1'b1;
    logic watchdog_fail = 1'b0, spi_sclk, spi_cs_n, spi_mosi, int_pulldown_en, reset_output;
    logic main_reg_enable, watchdog_halted, long_window_active, hardware_control_reg;
    logic main_reg_overvolt_reset_enable, wake_level_status_reg, latched_pin_config;
    logic dev_mode, power_on_flag, main_reg_overvolt_flag, main_reg_undervolt_flag;
    logic [2:0] wake_inputs = 3'h0, fail_outputs, wd_period;
    logic [1:0] mode_field, wd_fail_count;
    sbc_mode_pkg::sbc_state_t mode_state;
    int num_errors = 0, checks_done = 0;
    always #25 clk_sys = ~clk_sys;
    sbc_mode_state_machine #(.RESET_DELAY_CYCLES(RD), .LONG_WINDOW_CYCLES(50000)) i_dut (.*);
    sbc_host_model i_host (.*);
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic st(input string n, input logic [5:0] s);
        for (int i = 0; i < 2 * RD && mode_state !== s; i++) @(posedge clk_sys);
        chk(n, {2'h0, s}, {2'h0, mode_state});
    endtask : st
    // tg toggles the interrupt pin so the filter never settles
    task automatic pwr(input logic ip, input logic sp, input logic tg);
        resetn <= 1'b0;
        main_reg_ok_pin <= 1'b0;
        int_pin_in <= ip;
        fail3_test_strap_pin <= sp;
        repeat (5) @(posedge clk_sys);
        chk("ro", 8'h0, {7'h0, reset_output});
        chk("fo", 8'h0, {4'h0, main_reg_undervolt_flag, fail_outputs});
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        main_reg_ok_pin <= 1'b1;
        for (int i = 0; i < 2 * RD && reset_output !== 1'b1; i++) begin
            @(posedge clk_sys);
            if (tg) int_pin_in <= ~int_pin_in;
        end
        fail3_test_strap_pin <= 1'b1;
    endtask : pwr
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        report_and_stop();
    end
    initial begin
        pwr(1'b1, 1'b1, 1'b0);
        chk("latched_pin_config", 8'h1, {7'h0, latched_pin_config});
        chk("lw", 8'h1, {7'h0, long_window_active});
        wake_inputs <= 3'h1;
        repeat (8) @(posedge clk_sys);
        wake_inputs <= 3'h0;
        st("init", 6'h01);
        i_host.send(16'h8304, 8);
        st("init_exit", 6'h02);
        i_host.send(16'h8303, 16);
        i_host.send(16'h8201, 16);
        chk("cfg", 8'h1, {7'h0, hardware_control_reg});
        main_reg_overvolt_pin <= 1'b1;
        repeat (8) @(posedge clk_sys);
        main_reg_overvolt_pin <= 1'b0;
        chk("ov", 8'h1, {7'h0, main_reg_overvolt_flag});
        st("ov_mode", 6'h02);
        $display("test init done");
        i_host.send(16'h8101, 16);
        st("sleep", 6'h08);
        chk("vreg", 8'h0, {7'h0, main_reg_enable});
        bus_wake_pin <= 1'b1;
        st("wake", 6'h10);
        bus_wake_pin <= 1'b0;
        @(posedge clk_sys);
        chk("field", 8'h0, {6'h0, mode_field});
        st("back", 6'h02);
        chk("period", 8'h4, {5'h0, wd_period});
        watchdog_fail <= 1'b1;
        @(posedge clk_sys);
        watchdog_fail <= 1'b0;
        st("wd1", 6'h10);
        chk("fo1", 8'h7, {5'h0, fail_outputs});
        $display("test config one done");
        pwr(1'b1, 1'b1, 1'b1);
        chk("cfgp0", 8'h0, {7'h0, latched_pin_config});
        i_host.send(16'h8304, 16);
        for (int k = 0; k < 2; k++) begin
            st("norm", 6'h02);
            watchdog_fail <= 1'b1;
            @(posedge clk_sys);
            watchdog_fail <= 1'b0;
            st("wd", k ? 6'h20 : 6'h10);
            chk("fo", k ? 8'h17 : 8'h08, {3'h0, wd_fail_count, fail_outputs});
        end
        overtemp_pin <= 1'b1;
        repeat (8) @(posedge clk_sys);
        overtemp_pin <= 1'b0;
        st("ot", 6'h10);
        $display("test config zero done");
        pwr(1'b1, 1'b0, 1'b0);
        chk("dev", 8'h1, {7'h0, dev_mode});
        chk("halt", 8'h1, {7'h0, watchdog_halted});
        $display("test strap done");
        report_and_stop();
    end
endmodule : tb_sbc_mode_state_machine
